// ==== verilog/bridge_config_header_regs.sv ====
// Behaviour
// - Interrupt pending status bit always reads zero, forwarded INTx ignored.
// - Capabilities list status bit reads one; first pointer lives at 34h (34h is not decoded here and reads 00h).
// - 66 MHz, fast back-to-back and select timing status fields read zero.
// - Master data parity flag sets on primary parity error; resets zero.
// - Master data parity flag never sets while parity response disabled.
// - Signaled target abort sets when completing with completer abort.
// - Received target abort sets on completion with completer abort status.
// - Received master abort sets on completion with unsupported request status.
// - Signaled system error sets on error message while system error enabled.
// - Detected parity error sets on any poisoned TLP, regardless of enables.
// - Class code reads fixed 00h, 04h, 06h.
// - Eight-bit revision field returns a hardwired value.
// - Cache line size is read/write, resets 00h, affects nothing.
// - Primary and secondary latency timers read 00h, not writable.
// - Header type reads 01h.
// - Primary, secondary, subordinate bus numbers writable, reset 00h.
// - I/O base low nibble reads 1h, read-only.
// - I/O base upper nibble gives window bits 15:12, resets 0h.
// - I/O base with upper word forms lower forwarding bound.
// - Command bit enables parity error response.
// - Command bit enables system error reporting.
//
// Register access over AHB-Lite was left to the implementer.
`default_nettype none
module bridge_config_header_regs
  import bridge_cfg_pkg::*;
#(
  parameter logic [7:0] REVISION_VAL = 8'hA3, // Arbitrary value
  parameter int unsigned DEC_BITS    = 8      // Decoded low address bits
) (
  input  wire logic           hclk,          // Core clock
  input  wire logic           hresetn,       // Async reset, active low
  input  wire logic           hsel,          // Slave select
  input  wire logic [31:0]    haddr,         // Byte address
  input  wire logic [1:0]     htrans,        // Transfer type
  input  wire logic           hwrite,        // Write when high
  input  wire logic [2:0]     hsize,         // Transfer size
  input  wire logic [31:0]    hwdata,        // Write data
  input  wire logic           hready,        // Bus ready
  output logic                hreadyout,     // Slave ready
  output logic                hresp,         // Always OKAY
  output logic [31:0]         hrdata,        // Read data
  input  wire bridge_events_t events,        // One-cycle event pulses
  input  wire logic           io_req_valid,  // I/O address to compare
  input  wire logic [31:0]    io_req_addr,   // I/O address
  output logic                io_chk_valid,  // Comparison result valid
  output logic                io_above_base, // Address at or above base
  output logic                perr_resp_en,  // Parity error response enable
  output logic                serr_en,       // System error reporting enable
  output bus_nums_t           bus_nums       // Bus numbers for routing
);

  // Parameter checks
  initial begin
    if (DEC_BITS < 6 || DEC_BITS > 31) begin
      $error("DEC_BITS must lie between 6 and 31");
    end
  end

  logic                 accept;
  logic                 wr_pend;
  logic                 rd_pend;
  logic                 addr_hit;
  logic [7:0]           addr_ofs;
  logic [31:0]          rd_word;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [7:0]           cache_line;
  logic [3:0]           io_base_hi;
  logic [15:0]          io_base_up;
  logic [31:0]          io_bound;
  logic                 wr_cmd;

  // Address phase taken on a selected NONSEQ or SEQ transfer
  assign accept = hsel && hready && htrans[1];
  assign wr_cmd = wr_pend && addr_hit && (addr_ofs == OFS_CMD_STATUS);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      addr_hit <= 1'b0;
      addr_ofs <= 8'h00;
    end else if (hready) begin
      wr_pend <= accept && hwrite;
      rd_pend <= accept && !hwrite;
      if (accept) begin
        addr_hit <= (haddr[31:DEC_BITS] == '0) && (hsize == 3'h2);
        addr_ofs <= {haddr[7:2], 2'b00};
      end
    end
  end

  // One wait state on reads so a preceding write is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(hready && accept && !hwrite);
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Read data loaded in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend && !hreadyout) begin
      hrdata <= rd_word;
    end
  end

  // Read multiplexer; unlisted and reserved bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (!addr_hit) begin
      rd_word = 32'h0000_0000;
    end else if (addr_ofs == OFS_CMD_STATUS) begin
      rd_word[CMD_PERR_RESP_BIT] = perr_resp_en;
      rd_word[CMD_SERR_EN_BIT]   = serr_en;
      rd_word[STS_INT_PEND_BIT]  = 1'b0;
      rd_word[STS_CAP_LIST_BIT]  = CAP_LIST_VAL;
      for (int i = 0; i < NUM_FLAGS; i++) begin
        rd_word[FLAG_POS[i]] = flags[i];
      end
    end else if (addr_ofs == OFS_REV_CLASS) begin
      rd_word = {CLASS_BASE, CLASS_SUB, CLASS_PROG_IF, REVISION_VAL};
    end else if (addr_ofs == OFS_CACHE_HDR) begin
      rd_word = {8'h00, HEADER_TYPE_VAL, LATENCY_VAL, cache_line};
    end else if (addr_ofs == OFS_BUS_NUMS) begin
      rd_word = {LATENCY_VAL, bus_nums.subordinate, bus_nums.secondary, bus_nums.primary};
    end else if (addr_ofs == OFS_IO_BASE) begin
      rd_word = {24'h00_0000, io_base_hi, IO_ADDR_CAP};
    end else if (addr_ofs == OFS_IO_BASE_UP) begin
      rd_word = {16'h0000, io_base_up};
    end
  end

  // Command enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      perr_resp_en <= 1'b0;
      serr_en      <= 1'b0;
    end else if (wr_cmd) begin
      perr_resp_en <= hwdata[CMD_PERR_RESP_BIT];
      serr_en      <= hwdata[CMD_SERR_EN_BIT];
    end
  end

  // Flag set conditions
  always_comb begin
    flag_set[0] = events.parity_err && perr_resp_en;
    flag_set[1] = events.cpl_abort_sent;
    flag_set[2] = events.rx_cpl_abort;
    flag_set[3] = events.rx_cpl_unsup;
    flag_set[4] = events.err_msg_sent && serr_en;
    flag_set[5] = events.poisoned_rx;
  end

  // Sticky flags, set wins over clear
  for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_flag
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flags[g] <= 1'b0;
      end else begin
        flags[g] <= flag_set[g] || (flags[g] && !(wr_cmd && hwdata[FLAG_POS[g]]));
      end
    end
  end

  // Cache line size, stored only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cache_line <= CACHE_LINE_RST;
    end else if (wr_pend && addr_hit && addr_ofs == OFS_CACHE_HDR) begin
      cache_line <= hwdata[7:0];
    end
  end

  // Bus numbers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_nums <= '{default: BUS_NUM_RST};
    end else if (wr_pend && addr_hit && addr_ofs == OFS_BUS_NUMS) begin
      bus_nums <= hwdata[23:0];
    end
  end

  // I/O window base
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_base_hi <= IO_BASE_RST;
      io_base_up <= IO_BASE_UP_RST;
    end else if (wr_pend && addr_hit) begin
      if (addr_ofs == OFS_IO_BASE) begin
        io_base_hi <= hwdata[IO_BASE_LSB +: 4];
      end else if (addr_ofs == OFS_IO_BASE_UP) begin
        io_base_up <= hwdata[15:0];
      end
    end
  end

  assign io_bound = {io_base_up, io_base_hi, 12'h000};

  // Lower-bound forwarding check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_chk_valid  <= 1'b0;
      io_above_base <= 1'b0;
    end else begin
      io_chk_valid <= io_req_valid;
      if (io_req_valid) begin
        io_above_base <= (io_req_addr >= io_bound);
      end
    end
  end

endmodule
`default_nettype wire

// ==== verilog/bridge_cfg_pkg.sv ====
`default_nettype none
package bridge_cfg_pkg;

  // Byte offsets of the register words
  localparam logic [7:0] OFS_CMD_STATUS   = 8'h04;
  localparam logic [7:0] OFS_REV_CLASS    = 8'h08;
  localparam logic [7:0] OFS_CACHE_HDR    = 8'h0C;
  localparam logic [7:0] OFS_BUS_NUMS     = 8'h18;
  localparam logic [7:0] OFS_IO_BASE      = 8'h1C;
  localparam logic [7:0] OFS_IO_BASE_UP   = 8'h30;

  // Command half field positions
  localparam int unsigned CMD_PERR_RESP_BIT = 6;
  localparam int unsigned CMD_SERR_EN_BIT   = 8;

  // Status half field positions
  localparam int unsigned STS_INT_PEND_BIT  = 19;
  localparam int unsigned STS_CAP_LIST_BIT  = 20;
  localparam int unsigned NUM_FLAGS         = 6;
  // Sticky flags: data parity, sig target abort, rx target abort,
  // rx master abort, sig system error, detected parity
  localparam int unsigned FLAG_POS [NUM_FLAGS] = '{24, 27, 28, 29, 30, 31};

  // Fixed identification and layout values
  localparam logic [7:0] CLASS_PROG_IF    = 8'h00;
  localparam logic [7:0] CLASS_SUB        = 8'h04;
  localparam logic [7:0] CLASS_BASE       = 8'h06;
  localparam logic [7:0] HEADER_TYPE_VAL  = 8'h01;
  localparam logic [7:0] LATENCY_VAL      = 8'h00;
  localparam logic [3:0] IO_ADDR_CAP      = 4'h1;
  localparam logic       CAP_LIST_VAL     = 1'b1;

  // Reset values
  localparam logic [7:0]  CACHE_LINE_RST  = 8'h00;
  localparam logic [7:0]  BUS_NUM_RST     = 8'h00;
  localparam logic [3:0]  IO_BASE_RST     = 4'h0;
  localparam logic [15:0] IO_BASE_UP_RST  = 16'h0000;

  // Field positions inside the words
  localparam int unsigned IO_BASE_LSB     = 4;
  localparam int unsigned IO_WIN_LSB      = 12;

  // Events raised by the port's transaction logic
  typedef struct packed {
    logic parity_err;      // Parity error detected or forwarded, primary side
    logic cpl_abort_sent;  // Completed a request with completer abort
    logic rx_cpl_abort;    // Received completion with completer abort
    logic rx_cpl_unsup;    // Received completion with unsupported request
    logic err_msg_sent;    // Sent ERR_FATAL or ERR_NONFATAL
    logic poisoned_rx;     // Received poisoned TLP on primary side
  } bridge_events_t;

  // Bus numbers used by routing
  typedef struct packed {
    logic [7:0] subordinate;
    logic [7:0] secondary;
    logic [7:0] primary;
  } bus_nums_t;

endpackage
`default_nettype wire

// ==== tb/bridge_config_header_regs_props.sv ====
`default_nettype none
module bridge_cfg_props
  import bridge_cfg_pkg::*;
(
  input wire logic           hclk, hresetn, hsel, hwrite, hready,
  input wire logic           hreadyout, hresp, io_req_valid,
  input wire logic           io_chk_valid, io_above_base, perr_resp_en, serr_en,
  input wire logic [31:0]    haddr, hwdata, hrdata, io_req_addr,
  input wire logic [1:0]     htrans,
  input wire logic [2:0]     hsize,
  input wire bridge_events_t events,
  input wire bus_nums_t      bus_nums
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd;
  logic wr;
  // Accepted word reads and writes in the decoded space
  assign rd = hsel && hready && htrans[1] && hsize == 3'b010 && haddr[31:8] == 24'h0 && !hwrite;
  assign wr = hsel && hready && htrans[1] && hsize == 3'b010 && haddr[31:8] == 24'h0 && hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_rd_wait: assert property (rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  chk_status_fixed: assert property (rd && haddr[7:0] == OFS_CMD_STATUS |-> ##2
    hrdata[23:19] == 5'b00010 && hrdata[26:25] == 2'b00) else $error("fixed status bits");
  chk_class_code: assert property (rd && haddr[7:0] == OFS_REV_CLASS |-> ##2
    hrdata[31:8] == 24'h060400) else $error("class code wrong");
  chk_hdr_latency: assert property (rd && haddr[7:0] == OFS_CACHE_HDR |-> ##2
    hrdata[23:8] == 16'h0100) else $error("header or latency wrong");
  chk_bus_read: assert property (rd && haddr[7:0] == OFS_BUS_NUMS |-> ##2
    hrdata == {8'h00, bus_nums}) else $error("bus number word wrong");
  chk_io_nibble: assert property (rd && haddr[7:0] == OFS_IO_BASE |-> ##2
    hrdata[3:0] == 4'h1) else $error("io width nibble wrong");
  chk_cmd_write: assert property (wr && haddr[7:0] == OFS_CMD_STATUS |-> ##2
    {serr_en, perr_resp_en} == {$past(hwdata[8]), $past(hwdata[6])}) else $error("enables");
  chk_bus_write: assert property (wr && haddr[7:0] == OFS_BUS_NUMS |-> ##2
    bus_nums == $past(hwdata[23:0])) else $error("bus numbers not written");
  chk_io_timing: assert property (io_req_valid |=> io_chk_valid)
    else $error("io check late");
  cover property (rd && haddr[7:0] == OFS_CMD_STATUS);
  cover property (wr && haddr[7:0] == OFS_BUS_NUMS);
  cover property (io_req_valid ##1 io_above_base);
endmodule
bind bridge_config_header_regs bridge_cfg_props chk (.*);
`default_nettype wire

// ==== tb/test_bridge_config_header_regs.sv ====
`default_nettype none
module test_bridge_config_header_regs;
  import bridge_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h5A; // Arbitrary value
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, io_req_valid = 0;
  logic [31:0] haddr = '0, hwdata = '0, io_req_addr = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp, io_chk_valid, io_above_base, perr_resp_en, serr_en;
  bridge_events_t events = '0;
  bus_nums_t bus_nums;
  int n_errors = 0;
  int n_compared = 0;
  bridge_config_header_regs #(.REVISION_VAL(REV)) uut (.hready(hreadyout), .*);
  // Clock
  initial forever #5 hclk = ~hclk;
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One single AHB transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {3'b110, w, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'b000;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic pulse(input bridge_events_t e);
    @(posedge hclk);
    events <= e;
    @(posedge hclk);
    events <= '0;
  endtask
  task automatic io_chk(input logic [31:0] a, input logic e);
    @(posedge hclk);
    {io_req_valid, io_req_addr} <= {1'b1, a};
    @(posedge hclk);
    io_req_valid <= 1'b0;
    @(posedge hclk);
    chk({31'h0, io_above_base}, {31'h0, e});
  endtask
  task automatic do_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic t_reset;
    logic [31:0] a [6] = '{32'h04, 32'h08, 32'h0C, 32'h18, 32'h1C, 32'h30};
    logic [31:0] e [6] = '{32'h0010_0000, {24'h060400, REV}, 32'h0001_0000, 0, 1, 0};
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, a[i], '0);
      chk(rd, e[i]);
    end
    $display("reset values test done");
  endtask
  // All ones into every word except status; read-only parts must not move
  task automatic t_write;
    logic [31:0] a [6] = '{32'h08, 32'h0C, 32'h18, 32'h1C, 32'h30, 32'h40};
    logic [31:0] e [6] = '{{24'h060400, REV}, 32'h0001_00FF, 32'h00FF_FFFF, 32'hF1, 32'hFFFF, 0};
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, a[i], '1);
      xfer(1'b0, a[i], '0);
      chk(rd, e[i]);
    end
    xfer(1'b1, 32'h18, 32'h0003_0201);
    @(posedge hclk);
    chk({8'h0, bus_nums}, 32'h0003_0201);
    $display("write access test done");
  endtask
  task automatic t_events;
    xfer(1'b1, 32'h04, 32'h0);
    pulse('1);
    xfer(1'b0, 32'h04, '0);
    chk(rd, 32'hB810_0000);
    xfer(1'b1, 32'h04, 32'hFF00_0000);
    xfer(1'b0, 32'h04, '0);
    chk(rd, 32'h0010_0000);
    xfer(1'b1, 32'h04, 32'h140);
    pulse(6'b100010);
    xfer(1'b0, 32'h04, '0);
    chk(rd, 32'h4110_0140);
    xfer(1'b1, 32'h04, 32'h4000_0140);
    xfer(1'b0, 32'h04, '0);
    chk(rd, 32'h0110_0140);
    $display("status flag test done");
  endtask
  task automatic t_io;
    xfer(1'b1, 32'h1C, 32'h50);
    xfer(1'b1, 32'h30, 32'h1);
    io_chk(32'h0001_4FFF, 1'b0);
    io_chk(32'h0001_5000, 1'b1);
    io_chk(32'h0000_5000, 1'b0);
    $display("io window test done");
  endtask
  task automatic final_report;
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence, with a second reset in mid-run
  initial begin
    do_reset();
    t_reset();
    t_write();
    t_events();
    t_io();
    do_reset();
    t_reset();
    final_report();
  end
  // Watchdog well beyond the expected run
  initial begin
    #50000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
